// ==== rtl/ptbr_buf2.sv ====
// Purpose: Two-entry valid/ready buffer on the read data path
// Assumes: Synchronous reset, one clock
// Notes:   Full at two words; in_ready drops so the source must stall
`timescale 1ns/10ps
module ptbr_buf2 #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    // Fill side
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    // Drain side
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic [1:0]   cnt_q, cnt_d;
    logic         rd_q, rd_d;
    logic         wr_q, wr_d;
    logic         push, pop;
    logic         valid_q;

    always_comb begin
        push  = i_in_valid && (cnt_q != 2'h2);
        pop   = (cnt_q != 2'h0) && i_out_ready;
        mem_d = mem_q;
        cnt_d = cnt_q;
        rd_d  = rd_q;
        wr_d  = wr_q;
        if (push) begin
            mem_d[wr_q] = i_in_data;
            wr_d        = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        mem_q <= mem_d;
        if (i_rst) begin
            cnt_q <= 2'h0;
            valid_q <= 1'b0;
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            valid_q <= (cnt_d != 2'h0);
            rd_q  <= rd_d;
            wr_q  <= wr_d;
        end
    end

    assign o_in_ready  = (cnt_q != 2'h2);
    assign o_out_valid = valid_q;
    assign o_out_data  = mem_q[rd_q];
endmodule : ptbr_buf2

// ==== rtl/ptbr_pkg.sv ====
// Purpose: Shared constants for the pass-through burst read port
// Assumes: Single 20 MHz local-side clock
// Notes:   Register index values are those of the local register decode
package ptbr_pkg;
    localparam int          DATA_W         = 32;
    localparam int          ADDR_W         = 32;
    localparam int          IDX_W          = 5;
    localparam int          LANES          = 4;
    localparam int          CNT_W          = 8;
    // Local register index of the transfer data port (byte offset 2Ch, index = [6:2])
    localparam logic [6:0]  DATA_PORT_OFS  = 7'h2C;
    localparam logic [4:0]  DATA_PORT_IDX  = DATA_PORT_OFS[6:2];
    localparam logic [3:0]  LANES_NONE_N   = 4'hF;
    localparam logic [1:0]  REGION_RST     = 2'h0;
    localparam logic [CNT_W-1:0] ONE_PHASE = 8'h01;
    localparam logic [CNT_W-1:0] TWO_PHASE = 8'h02;
    // Without prefetch a burst is cut into packets of this many phases
    localparam logic [CNT_W-1:0] PKT_MAX   = 8'h02;
    typedef enum logic [1:0] {
        PTBR_IDLE,
        PTBR_ACTIVE,
        PTBR_DONE
    } ptbr_state_t;
endpackage : ptbr_pkg

// ==== rtl/ptbr_port.sv ====
// Purpose: Local-side pass-through burst read port of a PCI target
// Assumes: All inputs synchronous to i_clk_sys; PCI side presents accesses as pulses
// Notes:   Read data goes through a two-entry buffer toward the PCI-side FIFO
//
// Overview of operation
// - On a read hit, capture the PCI address and request data from local logic.
// - Status outputs update on the clock edge after the access is recognised.
// - region_index carries the number of the region being accessed.
// - transfer_is_store stays low for reads, so local logic must supply data.
// - multi_phase_n is low while more than one data phase remains in the current packet.
// - pending_byte_lanes_n shows the requested lanes, reloaded unchanged on each completion but a packet's last, which sets them all high.
// - While address_out_strobe_n is low, address drives the data bus without a clock.
// - Each edge with write and data register selected during a pending read stores the bus word if the buffer has room.
// - A phase completes only on phase_done_n low; phase counts then decrement and lanes reload, or go all high on a packet's last phase.
// - Completing the second-to-last phase releases multi_phase_n.
// - Completing the final phase releases access_pending_n.
// - With both status signals released after a burst's last packet, ready returns next clock and a new access is taken the clock after.
// - Without prefetch, bursts split into packets of two, pending released between.
// - An edge with write and phase_done_n both high stores nothing, advances nothing.
`timescale 1ns/10ps
module ptbr_port #(
    parameter int DATA_W = ptbr_pkg::DATA_W,
    parameter int ADDR_W = ptbr_pkg::ADDR_W,
    parameter int CNT_W  = ptbr_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // PCI-side access request
    input  wire logic              i_pci_req,
    input  wire logic              i_pci_is_store,
    input  wire logic [ADDR_W-1:0] i_pci_addr,
    input  wire logic [1:0]        i_pci_region,
    input  wire logic [CNT_W-1:0]  i_pci_phases,
    input  wire logic [3:0]        i_pci_lanes_n,
    input  wire logic              i_prefetch_en,
    output logic                   o_pci_req_ready,
    // PCI-side read FIFO feed
    output logic                   o_fifo_valid,
    input  wire logic              i_fifo_ready,
    output logic [DATA_W-1:0]      o_fifo_data,
    output logic                   o_local_stall,
    // Pass-through status
    output logic                   o_access_pending_n,
    output logic                   o_multi_phase_n,
    output logic [1:0]             o_region_index,
    output logic                   o_transfer_is_store,
    output logic [3:0]             o_pending_byte_lanes_n,
    // Local register access
    input  wire logic              i_address_out_strobe_n,
    input  wire logic              i_phase_done_n,
    input  wire logic [3:0]        i_local_lane_sel_n,
    input  wire logic [4:0]        i_local_reg_index,
    input  wire logic              i_local_chip_sel_n,
    input  wire logic              i_local_write_n,
    // Local data bus, split
    input  wire logic [DATA_W-1:0] i_local_data,
    output logic [DATA_W-1:0]      o_local_data,
    output logic                   o_local_data_oe
);
    ptbr_pkg::ptbr_state_t st_q, st_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [CNT_W-1:0]  left_q, left_d;
    logic [CNT_W-1:0]  pkt_q, pkt_d;
    logic              pend_q, pend_d;
    logic              pend_n_q;
    logic              mph_q, mph_d;
    logic [1:0]        reg_q, reg_d;
    logic              store_q, store_d;
    logic [3:0]        lanes_q, lanes_d;
    logic [3:0]        req_lanes_q, req_lanes_d;
    logic              ready_q, ready_d;
    logic              stall_q, stall_d;
    logic              data_sel;
    logic              wr_word;
    logic              phase_done;
    logic              buf_in_ready;
    logic [DATA_W-1:0] buf_data;
    logic              buf_valid;

    // Packet length: without prefetch no more than two phases are offered at once
    function automatic logic [CNT_W-1:0] pkt_len(input logic [CNT_W-1:0] n,
                                                 input logic              pf);
        pkt_len = (!pf && (n > ptbr_pkg::PKT_MAX)) ? ptbr_pkg::PKT_MAX : n;
    endfunction : pkt_len

    always_comb begin
        // A write with no lane selected carries no byte, so it is not a word
        data_sel   = !i_local_chip_sel_n && (i_local_reg_index == ptbr_pkg::DATA_PORT_IDX)
                     && (i_local_lane_sel_n != ptbr_pkg::LANES_NONE_N);
        wr_word    = pend_q && !store_q && data_sel && !i_local_write_n;
        // A phase with data only counts while the buffer can take the word
        phase_done = pend_q && !i_phase_done_n && buf_in_ready;
    end

    always_comb begin
        st_d        = st_q;
        addr_d      = addr_q;
        left_d      = left_q;
        pkt_d       = pkt_q;
        pend_d      = pend_q;
        mph_d       = mph_q;
        reg_d       = reg_q;
        store_d     = store_q;
        lanes_d     = lanes_q;
        req_lanes_d = req_lanes_q;
        ready_d     = 1'b0;
        stall_d     = !buf_in_ready;
        unique case (st_q)
            ptbr_pkg::PTBR_IDLE: begin
                ready_d = 1'b1;
                if (i_pci_req && ready_q && (i_pci_phases != '0)) begin
                    ready_d     = 1'b0;
                    addr_d      = i_pci_addr;
                    left_d      = i_pci_phases;
                    pkt_d       = pkt_len(i_pci_phases, i_prefetch_en);
                    pend_d      = 1'b1;
                    mph_d       = pkt_len(i_pci_phases, i_prefetch_en) <= ptbr_pkg::ONE_PHASE;
                    reg_d       = i_pci_region;
                    store_d     = i_pci_is_store;
                    lanes_d     = i_pci_lanes_n;
                    req_lanes_d = i_pci_lanes_n;
                    st_d        = ptbr_pkg::PTBR_ACTIVE;
                end
            end
            ptbr_pkg::PTBR_ACTIVE: begin
                if (phase_done) begin
                    left_d  = left_q - ptbr_pkg::ONE_PHASE;
                    pkt_d   = pkt_q - ptbr_pkg::ONE_PHASE;
                    lanes_d = req_lanes_q;
                    if (pkt_q == ptbr_pkg::TWO_PHASE) begin
                        mph_d = 1'b1;
                    end
                    if (pkt_q == ptbr_pkg::ONE_PHASE) begin
                        pend_d  = 1'b0;
                        mph_d   = 1'b1;
                        lanes_d = ptbr_pkg::LANES_NONE_N;
                        st_d    = ptbr_pkg::PTBR_DONE;
                    end
                end
            end
            ptbr_pkg::PTBR_DONE: begin
                // Gap between packets; next packet starts one clock later
                if (left_q != '0) begin
                    pkt_d  = pkt_len(left_q, i_prefetch_en);
                    pend_d = 1'b1;
                    mph_d  = pkt_len(left_q, i_prefetch_en) <= ptbr_pkg::ONE_PHASE;
                    lanes_d = req_lanes_q;
                    st_d   = ptbr_pkg::PTBR_ACTIVE;
                end else begin
                    ready_d = 1'b1;
                    st_d    = ptbr_pkg::PTBR_IDLE;
                end
            end
            default: begin
                st_d = ptbr_pkg::PTBR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_q        <= ptbr_pkg::PTBR_IDLE;
            addr_q      <= '0;
            left_q      <= '0;
            pkt_q       <= '0;
            pend_q      <= 1'b0;
            pend_n_q    <= 1'b1;
            mph_q       <= 1'b1;
            reg_q       <= ptbr_pkg::REGION_RST;
            store_q     <= 1'b0;
            lanes_q     <= ptbr_pkg::LANES_NONE_N;
            req_lanes_q <= ptbr_pkg::LANES_NONE_N;
            ready_q     <= 1'b0;
            stall_q     <= 1'b0;
        end else begin
            st_q        <= st_d;
            addr_q      <= addr_d;
            left_q      <= left_d;
            pkt_q       <= pkt_d;
            pend_q      <= pend_d;
            pend_n_q    <= !pend_d;
            mph_q       <= mph_d;
            reg_q       <= reg_d;
            store_q     <= store_d;
            lanes_q     <= lanes_d;
            req_lanes_q <= req_lanes_d;
            ready_q     <= ready_d;
            stall_q     <= stall_d;
        end
    end

    // Word store path; buffer absorbs a PCI-side stall without dropping data
    ptbr_buf2 #(
        .W (DATA_W)
    ) u_buf (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_in_valid  (wr_word),
        .o_in_ready  (buf_in_ready),
        .i_in_data   (i_local_data),
        .o_out_valid (buf_valid),
        .i_out_ready (i_fifo_ready),
        .o_out_data  (buf_data)
    );

    assign o_fifo_valid           = buf_valid;
    assign o_fifo_data            = buf_data;
    assign o_local_stall          = stall_q;
    assign o_pci_req_ready        = ready_q;
    assign o_access_pending_n     = pend_n_q;
    assign o_multi_phase_n        = mph_q;
    assign o_region_index         = reg_q;
    assign o_transfer_is_store    = store_q;
    assign o_pending_byte_lanes_n = lanes_q;
    // Asynchronous address read: pure propagation path, not gated by reset
    assign o_local_data           = addr_q;
    assign o_local_data_oe        = !i_address_out_strobe_n;
endmodule : ptbr_port

// ==== tb/ptbr_addon_model.sv ====
// Purpose: Local logic that answers pass-through reads with numbered words
// Assumes: Paced mode only when the drain may stall
// Notes:   Back-to-back mode cannot see a refusal, so the bench never stalls it
`timescale 1ns/10ps
module ptbr_addon_model #(
    parameter logic [31:0] BASE = 32'hC0DE0000
) (
    // Clock and reset
    input  wire logic  i_clk_sys,
    input  wire logic  i_rst,
    // Mode and device status
    input  wire logic  i_paced,
    input  wire logic  i_addr_rd,
    input  wire logic  i_access_pending_n,
    input  wire logic  i_multi_phase_n,
    input  wire logic  i_local_stall,
    // Local bus drive
    output logic       o_address_out_strobe_n,
    output logic       o_phase_done_n,
    output logic [3:0] o_local_lane_sel_n,
    output logic [4:0] o_local_reg_index,
    output logic       o_local_chip_sel_n,
    output logic       o_local_write_n,
    output logic [31:0] o_local_data
);
    logic [2:0]  st_q;
    logic [31:0] cnt_q;
    logic        wr;
    assign wr = (st_q == 3'h3);
    assign o_address_out_strobe_n = (st_q != 3'h1);
    assign o_phase_done_n = !wr;
    assign o_local_write_n = !wr;
    assign o_local_chip_sel_n = !wr;
    assign o_local_lane_sel_n = wr ? 4'h0 : 4'hF;
    assign o_local_reg_index = wr ? ptbr_pkg::DATA_PORT_IDX : ~ptbr_pkg::DATA_PORT_IDX;
    // A released bus shows the inverse so a stale word never passes as fresh
    assign o_local_data = wr ? (BASE + cnt_q) : ~(BASE + cnt_q);
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_q <= 3'h0;
            cnt_q <= 32'h0;
        end else begin
            case (st_q)
                3'h0: if (!i_access_pending_n) st_q <= i_addr_rd ? 3'h1 : 3'h3;
                3'h1: st_q <= 3'h2;
                3'h2: st_q <= 3'h3;
                3'h3: if (i_paced) st_q <= 3'h4;
                      else begin
                          cnt_q <= cnt_q + 32'h1;
                          if (i_multi_phase_n) st_q <= 3'h5;
                      end
                3'h4: if (i_local_stall) st_q <= 3'h3;
                      else begin
                          cnt_q <= cnt_q + 32'h1;
                          st_q <= i_access_pending_n ? 3'h0 : 3'h3;
                      end
                default: if (i_access_pending_n) st_q <= 3'h0;
            endcase
        end
    end
endmodule : ptbr_addon_model

// ==== tb/ptbr_port_checker.sv ====
// Purpose: Port-level assertions for the pass-through burst read port
// Assumes: One clock, synchronous active-high reset
// Notes:   Status fields are judged at the edge after an access is taken
`timescale 1ns/10ps
module ptbr_port_checker #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic             i_clk_sys,
    input wire logic             i_rst,
    // Request side
    input wire logic             i_pci_req,
    input wire logic             i_pci_is_store,
    input wire logic [1:0]       i_pci_region,
    input wire logic [CNT_W-1:0] i_pci_phases,
    input wire logic [3:0]       i_pci_lanes_n,
    input wire logic             o_pci_req_ready,
    // Status and local side
    input wire logic             o_access_pending_n,
    input wire logic             o_multi_phase_n,
    input wire logic [1:0]       o_region_index,
    input wire logic             o_transfer_is_store,
    input wire logic [3:0]       o_pending_byte_lanes_n,
    input wire logic             i_address_out_strobe_n,
    input wire logic             i_phase_done_n,
    input wire logic             o_local_data_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic taken;
    assign taken = i_pci_req && o_pci_req_ready && (i_pci_phases != '0);
    AST_TAKE_PENDING: assert property (taken |=> !o_access_pending_n)
        else $error("pending not raised after access");
    AST_FIELDS: assert property (taken |=> o_region_index == $past(i_pci_region)
        && o_pending_byte_lanes_n == $past(i_pci_lanes_n)) else $error("status fields wrong");
    AST_READ_DIR: assert property (taken && !i_pci_is_store |=> !o_transfer_is_store)
        else $error("read shown as store");
    AST_MULTI: assert property (taken |=> o_multi_phase_n == ($past(i_pci_phases) < 8'h02))
        else $error("multi-phase flag wrong");
    AST_ADDR_OE: assert property (o_local_data_oe == !i_address_out_strobe_n)
        else $error("address drive not following strobe");
    AST_NO_PHASE: assert property (!o_access_pending_n && i_phase_done_n |=>
        $stable(o_access_pending_n) && $stable(o_multi_phase_n)
        && $stable(o_pending_byte_lanes_n)) else $error("status moved without phase done");
    AST_MULTI_RISE: assert property ($rose(o_multi_phase_n) |->
        !$past(i_phase_done_n) && !o_access_pending_n) else $error("multi-phase released early");
    AST_PEND_RISE: assert property ($rose(o_access_pending_n) |->
        !$past(i_phase_done_n) && o_multi_phase_n) else $error("pending released early");
    AST_RST_IDLE: assert property ($fell(i_rst) |-> o_access_pending_n && o_multi_phase_n)
        else $error("status not idle after reset");
    cover property (taken && i_pci_phases > 8'h04);
    cover property (!i_address_out_strobe_n);
    cover property (!o_access_pending_n && i_phase_done_n ##1 !i_phase_done_n);
endmodule : ptbr_port_checker

bind ptbr_port ptbr_port_checker #(.CNT_W(CNT_W)) u_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pci_req(i_pci_req),
    .i_pci_is_store(i_pci_is_store), .i_pci_region(i_pci_region),
    .i_pci_phases(i_pci_phases), .i_pci_lanes_n(i_pci_lanes_n),
    .o_pci_req_ready(o_pci_req_ready), .o_access_pending_n(o_access_pending_n),
    .o_multi_phase_n(o_multi_phase_n), .o_region_index(o_region_index),
    .o_transfer_is_store(o_transfer_is_store), .o_pending_byte_lanes_n(o_pending_byte_lanes_n),
    .i_address_out_strobe_n(i_address_out_strobe_n), .i_phase_done_n(i_phase_done_n),
    .o_local_data_oe(o_local_data_oe));

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the pass-through burst read port
// Assumes: Words arrive in order as BASE plus a running count
// Notes:   Even bursts run without prefetch to exercise packet splitting
`timescale 1ns/10ps
module tb_top;
    localparam logic [31:0] BASE = 32'hC0DE0000;
    logic        i_clk_sys = 1'b0, i_rst = 1'b1, req = 1'b0, pf = 1'b0, paced = 1'b0;
    logic        addr_rd = 1'b0, fifo_rdy = 1'b1, is_store = 1'b0, prev_pend_n = 1'b1;
    logic [31:0] addr = '0, fdata, ldata, bus;
    logic [7:0]  phases = '0;
    logic [3:0]  lanes_n = 4'hF, lanes, sel_n;
    logic [4:0]  idx;
    logic [1:0]  region = '0, reg_out;
    logic        rdy, fvalid, stall, pend_n, mph_n, store, strobe_n, pdone_n, cs_n, wr_n, oe;
    int          seed = 19, fails = 0, num_checks = 0, exp_k = 0, total = 0, falls = 0;
    int          cyc = 0, n;
    always #25 i_clk_sys = ~i_clk_sys;
    ptbr_port dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pci_req(req),
        .i_pci_is_store(is_store), .i_pci_addr(addr), .i_pci_region(region),
        .i_pci_phases(phases), .i_pci_lanes_n(lanes_n), .i_prefetch_en(pf),
        .o_pci_req_ready(rdy), .o_fifo_valid(fvalid), .i_fifo_ready(fifo_rdy),
        .o_fifo_data(fdata), .o_local_stall(stall), .o_access_pending_n(pend_n),
        .o_multi_phase_n(mph_n), .o_region_index(reg_out), .o_transfer_is_store(store),
        .o_pending_byte_lanes_n(lanes), .i_address_out_strobe_n(strobe_n),
        .i_phase_done_n(pdone_n), .i_local_lane_sel_n(sel_n), .i_local_reg_index(idx),
        .i_local_chip_sel_n(cs_n), .i_local_write_n(wr_n), .i_local_data(bus),
        .o_local_data(ldata), .o_local_data_oe(oe));
    ptbr_addon_model #(.BASE(BASE)) u_addon (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_paced(paced), .i_addr_rd(addr_rd), .i_access_pending_n(pend_n),
        .i_multi_phase_n(mph_n), .i_local_stall(stall), .o_address_out_strobe_n(strobe_n),
        .o_phase_done_n(pdone_n), .o_local_lane_sel_n(sel_n), .o_local_reg_index(idx),
        .o_local_chip_sel_n(cs_n), .o_local_write_n(wr_n), .o_local_data(bus));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic wait_ready;
        int t;
        t = 0;
        // Ready is looked at mid-cycle; the request then starts at the next rising edge
        do begin
            @(negedge i_clk_sys);
            t++;
        end while (rdy !== 1'b1 && t < 400);
        if (t >= 400) begin
            fails++;
            wrap_up();
        end
        @(posedge i_clk_sys);
    endtask : wait_ready
    // Paced bursts stall the drain mostly, so the two-entry buffer fills and refuses
    always @(posedge i_clk_sys) begin
        cyc++;
        fifo_rdy <= paced ? (($random(seed) & 3) == 0) : 1'b1;
        if (!i_rst && fvalid && fifo_rdy) begin
            check(fdata, BASE + exp_k);
            exp_k++;
        end
        if (!i_rst && !strobe_n) begin
            check(ldata, addr);
        end
        if (pend_n === 1'b0 && prev_pend_n === 1'b1) falls++;
        prev_pend_n <= pend_n;
        // Fourteen bursts need well under a thousand cycles even when stalled
        if (cyc > 20000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        check(pend_n & mph_n, 1);
        for (int b = 0; b < 14; b++) begin
            wait_ready();
            n = 1 + ({$random(seed)} % 5);
            pf <= b[0];
            paced <= (b % 3 == 0);
            addr_rd <= b[1];
            addr <= $random(seed);
            region <= $random(seed);
            lanes_n <= $random(seed);
            phases <= n;
            req <= 1'b1;
            falls = 0;
            @(posedge i_clk_sys);
            req <= 1'b0;
            @(negedge i_clk_sys);
            check(pend_n, 0);
            check(mph_n, n < 2);
            check(reg_out, region);
            check(store, 0);
            check(lanes, lanes_n);
            total += n;
            wait_ready();
            paced <= 1'b0;
            repeat (6) @(posedge i_clk_sys);
            check(exp_k, total);
            check(falls, pf ? 1 : (n + 1) / 2);
            check(mph_n & pend_n, 1);
        end
        wrap_up();
    end
endmodule : tb_top
